// file: dv/ddr_cio_burst2_sram_read_port_tb_top.sv
// Purpose: both ends back to back, command and read-back tests
// Assumes: inputs driven at falling clk edge
// Notes:   read words are collected in a queue
module ddr_cio_burst2_sram_read_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [ddrs_pkg::DATA_W-1:0] ddrs_word_t;
    logic        clk, nrst, single_clk_mode, dll_enable, cmd_valid, cmd_ready;
    logic        cmd_read, rd_valid, rd_ready, dll_active, single_clk_seen, read_busy;
    logic [19:0] cmd_addr;
    logic [1:0]  cmd_bw_n;
    ddrs_word_t  cmd_wdata0, cmd_wdata1, rd_data;
    ddrs_word_t  rq[$];
    int          failures, num_checks, n;

    ddrs_link_if u_ddrs_link_if ();
    ddrs_sram_dev u_ddrs_sram_dev (.clk(clk), .nrst(nrst), .link(u_ddrs_link_if.device),
        .dll_active(dll_active), .single_clk_seen(single_clk_seen), .read_busy(read_busy));
    ddrs_sram_ctl u_ddrs_sram_ctl (.clk(clk), .nrst(nrst), .single_clk_mode(single_clk_mode),
        .dll_enable(dll_enable), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata0(cmd_wdata0),
        .cmd_wdata1(cmd_wdata1), .cmd_bw_n(cmd_bw_n), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .rd_data(rd_data), .link(u_ddrs_link_if.controller));
    ddrs_link_sva u_ddrs_link_sva (.clk(clk), .nrst(nrst), .k(u_ddrs_link_if.k),
        .k_n(u_ddrs_link_if.k_n), .load_n(u_ddrs_link_if.load_n),
        .read_not_write(u_ddrs_link_if.read_not_write),
        .byte_write_n(u_ddrs_link_if.byte_write_n),
        .ctl_data_oe_n(u_ddrs_link_if.ctl_data_oe_n),
        .dev_data_oe_n(u_ddrs_link_if.dev_data_oe_n), .echo_clock(u_ddrs_link_if.echo_clock),
        .echo_clock_n(u_ddrs_link_if.echo_clock_n));

    // ------------------------------------------------------------
    // clock, collection, watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // gather read words
    always @(posedge clk) if (rd_valid === 1'b1 && rd_ready === 1'b1) rq.push_back(rd_data);
    // cut a hang short
    initial begin
        #200000;
        failures++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input ddrs_word_t seen, input ddrs_word_t exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // hold the command until it shows on the pins
    task automatic issue(input logic rd, input logic [19:0] a, input ddrs_word_t w0,
                         input ddrs_word_t w1, input logic [1:0] bw);
        @(negedge clk);
        {cmd_valid, cmd_read, cmd_addr, cmd_wdata0, cmd_wdata1, cmd_bw_n} = {1'b1, rd, a, w0, w1, bw};
        n = 0;
        do begin @(negedge clk); n++; end while (u_ddrs_link_if.load_n !== 1'b0 && n < 50);
        cmd_valid = 1'b0;
        if (n >= 50) failures++;
    endtask
    task automatic pop(input ddrs_word_t exp);
        n = 0;
        while (rq.size() == 0 && n < 40) begin @(negedge clk); n++; end
        if (rq.size() == 0) failures++;
        else check(rq.pop_front(), exp);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        {nrst, single_clk_mode, dll_enable, cmd_valid, cmd_read, rd_ready} = 6'h09;
        {cmd_addr, cmd_wdata0, cmd_wdata1, cmd_bw_n} = {56'h0, 2'h3};
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        issue(1'b0, 20'h00010, 18'h12345, 18'h0abcd, 2'h0);
        issue(1'b0, 20'h00020, 18'h3ffff, 18'h3ffff, 2'h0);
        issue(1'b0, 20'h00020, 18'h0, 18'h0, 2'h2);
        issue(1'b1, 20'h00011, 18'h0, 18'h0, 2'h3);
        issue(1'b1, 20'h00020, 18'h0, 18'h0, 2'h3);
        pop(18'h0abcd);
        pop(18'h12345);
        pop(18'h3fe00);
        pop(18'h3fe00);
        $display("test 1 done");
        rd_ready = 1'b0;
        for (int i = 0; i < 6; i++) issue(1'b1, 20'h00010, 18'h0, 18'h0, 2'h3);
        repeat (12) @(negedge clk);
        check(ddrs_word_t'(cmd_ready), 18'h0);
        @(negedge clk);
        check(ddrs_word_t'(cmd_ready), 18'h0);
        rd_ready = 1'b1;
        for (int i = 0; i < 6; i++) begin
            pop(18'h12345);
            pop(18'h0abcd);
        end
        $display("test 2 done");
        dll_enable = 1'b0;
        repeat (4) @(negedge clk);
        check(ddrs_word_t'(dll_active), 18'h0);
        dll_enable = 1'b1;
        repeat (4) @(negedge clk);
        check(ddrs_word_t'(dll_active), 18'h1);
        check(ddrs_word_t'(read_busy), 18'h0);
        $display("test 3 done");
        {nrst, single_clk_mode} = 2'h1;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        issue(1'b0, 20'h00030, 18'h15555, 18'h0aaaa, 2'h0);
        issue(1'b1, 20'h00030, 18'h0, 18'h0, 2'h3);
        repeat (4) @(negedge clk);
        check(ddrs_word_t'(read_busy), 18'h1);
        pop(18'h15555);
        pop(18'h0aaaa);
        check(ddrs_word_t'(single_clk_seen), 18'h1);
        $display("test 4 done");
        end_of_test();
    end
endmodule // ddr_cio_burst2_sram_read_port_tb_top

// file: dv/ddrs_link_sva.sv
// Purpose: protocol checks on the link pins
// Assumes: both ends on one clk
// Notes:   counts are cycles after the command cycle
module ddrs_link_sva (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       k,
    input wire logic       k_n,
    input wire logic       load_n,
    input wire logic       read_not_write,
    input wire logic [1:0] byte_write_n,
    input wire logic       ctl_data_oe_n,
    input wire logic       dev_data_oe_n,
    input wire logic       echo_clock,
    input wire logic       echo_clock_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // link checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence rd_cmd; !load_n && read_not_write; endsequence
    sequence wr_cmd; !load_n && !read_not_write; endsequence
    a_k_pair: assert property (k_n == !k) else $error("k pair");
    a_cmd_on_k: assert property (!load_n |-> k) else $error("cmd off k");
    a_cmd_gap: assert property (!load_n |=> load_n) else $error("cmd gap");
    a_rd_burst: assert property (rd_cmd |-> ##4 !dev_data_oe_n [*2])
        else $error("read burst");
    a_rd_window: assert property (!dev_data_oe_n |->
        $past(!load_n && read_not_write, 4) || $past(!load_n && read_not_write, 5))
        else $error("drive outside burst");
    a_wr_burst: assert property (wr_cmd |-> ##2 !ctl_data_oe_n [*2] ##1
        (ctl_data_oe_n || (!$past(load_n, 2) && !$past(read_not_write, 2))))
        else $error("write burst");
    a_bw_idle: assert property (ctl_data_oe_n |-> byte_write_n == 2'h3)
        else $error("lane enable idle");
    a_echo_pair: assert property (echo_clock_n == !echo_clock) else $error("echo pair");
    a_echo_runs: assert property (1 |-> ##[1:3] $changed(echo_clock))
        else $error("echo stopped");
endmodule // ddrs_link_sva

// file: hdl/ddrs_sram_ctl.sv
// Purpose: controller end: makes the link clocks, issues commands, buffers read data
// Assumes: same clk as the device; one device on the link
// Notes:   a write offered one slot after a read is held back to avoid a bus clash

// ----------------------------------------------------------------------
// return buffer
// ----------------------------------------------------------------------
module ddrs_fifo #(
    parameter int W     = ddrs_pkg::DATA_W,
    parameter int DEPTH = ddrs_pkg::FIFO_DEPTH,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data,
    output logic [AW:0]       level
);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } ddrs_fifo_st_t;

    ddrs_fifo_st_t s;
    ddrs_fifo_st_t next_s;
    logic [W-1:0]  mem [0:DEPTH-1];
    logic          push;
    logic          pop;

    assign level     = s.wp - s.rp;
    assign in_ready  = (level != (AW+1)'(DEPTH));
    assign out_valid = (s.wp != s.rp);
    assign out_data  = mem[s.rp[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer advance
    always_comb begin
        next_s = s;
        if (push) next_s.wp = s.wp + 1'b1;
        if (pop) next_s.rp = s.rp + 1'b1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) s <= '0;
        else s <= next_s;
    end

    // storage
    always_ff @(posedge clk) begin
        if (push) mem[s.wp[AW-1:0]] <= in_data;
    end
endmodule : ddrs_fifo

// ----------------------------------------------------------------------
// controller
// ----------------------------------------------------------------------
module ddrs_sram_ctl #(
    parameter int ADDR_W = ddrs_pkg::ADDR_W,
    parameter int DATA_W = ddrs_pkg::DATA_W,
    parameter int LANES  = ddrs_pkg::LANES,
    parameter int DEPTH  = ddrs_pkg::FIFO_DEPTH
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              single_clk_mode,
    input  wire logic              dll_enable,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire logic              cmd_read,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [DATA_W-1:0] cmd_wdata0,
    input  wire logic [DATA_W-1:0] cmd_wdata1,
    input  wire logic [LANES-1:0]  cmd_bw_n,
    output logic                   rd_valid,
    input  wire logic              rd_ready,
    output logic [DATA_W-1:0]      rd_data,
    ddrs_link_if.controller        link
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic                        k;
        logic                        k_n;
        logic                        c;
        logic                        c_n;
        logic                        mode_known;
        logic                        single;
        logic                        load_n;
        logic                        rnw;
        logic [ADDR_W-1:0]           addr;
        logic [LANES-1:0]            bw_n;
        logic [DATA_W-1:0]           dq_o;
        logic                        dq_oe_n;
        logic                        dll_off_n;
        logic                        cmd_ready;
        logic [ddrs_pkg::RD_SH_W-1:0] rd_sh;
        logic [ddrs_pkg::WR_SH_W-1:0] wr_sh;
        logic [DATA_W-1:0]           wd0;
        logic [DATA_W-1:0]           wd1;
        logic [LANES-1:0]            wbw;
        logic [DATA_W-1:0]           wd1_hold;
        logic [LANES-1:0]            wbw_hold;
    } ddrs_ctl_st_t;

    ddrs_ctl_st_t  s;
    ddrs_ctl_st_t  next_s;
    logic          take;
    logic          cap_valid;
    logic          cap_ready;
    logic [AW:0]   level;

    // take only at a true-edge slot; write waits if a read just went
    assign take = cmd_valid && s.cmd_ready && (cmd_read || !s.rd_sh[1]);

    // sample the bus only inside the read window, phased by the echo pair
    assign cap_valid = (s.rd_sh[ddrs_pkg::RD_WORD1_CYC] && link.echo_clock_n) ||
                       (s.rd_sh[ddrs_pkg::RD_WORD2_CYC] && link.echo_clock);

    // next state: clocks, command issue, write data
    always_comb begin
        next_s           = s;
        next_s.k         = ~s.k;
        next_s.k_n       = s.k;
        next_s.dll_off_n = dll_enable;
        if (!s.mode_known) begin
            next_s.mode_known = 1'b1;
            next_s.single     = single_clk_mode;
        end
        next_s.c       = next_s.single ? 1'b1 : ~s.k;
        next_s.c_n     = next_s.single ? 1'b1 : s.k;
        next_s.rd_sh   = {s.rd_sh[ddrs_pkg::RD_SH_W-2:0], 1'b0};
        next_s.wr_sh   = {s.wr_sh[ddrs_pkg::WR_SH_W-2:0], 1'b0};
        next_s.load_n  = 1'b1;
        next_s.rnw     = 1'b1;
        if (take) begin
            next_s.load_n   = 1'b0;
            next_s.rnw      = cmd_read;
            next_s.addr     = cmd_addr;
            next_s.rd_sh[0] = cmd_read;
            next_s.wr_sh[0] = ~cmd_read;
            next_s.wd0      = cmd_wdata0;
            next_s.wd1      = cmd_wdata1;
            next_s.wbw      = cmd_bw_n;
        end
        // write words one and two on the next true and bar edges
        // word two kept aside: a command taken now reloads wd1 and wbw
        if (s.wr_sh[1]) begin
            next_s.dq_o     = s.wd0;
            next_s.dq_oe_n  = 1'b0;
            next_s.bw_n     = s.wbw;
            next_s.wd1_hold = s.wd1;
            next_s.wbw_hold = s.wbw;
        end else if (s.wr_sh[2]) begin
            next_s.dq_o    = s.wd1_hold;
            next_s.dq_oe_n = 1'b0;
            next_s.bw_n    = s.wbw_hold;
        end else begin
            next_s.dq_oe_n = 1'b1;
            next_s.bw_n    = ddrs_pkg::BW_NONE;
        end
        // ready next cycle only before a true edge and with buffer room
        next_s.cmd_ready = !next_s.k && next_s.mode_known &&
                           (level <= (AW+1)'(DEPTH - ddrs_pkg::FIFO_SLACK));
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s           <= '0;
            s.k_n       <= 1'b1;
            s.c         <= 1'b1;
            s.c_n       <= 1'b1;
            s.load_n    <= 1'b1;
            s.rnw       <= 1'b1;
            s.bw_n      <= ddrs_pkg::BW_NONE;
            s.dq_oe_n   <= 1'b1;
            s.dll_off_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // read return buffer
    ddrs_fifo #(
        .W     (DATA_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (cap_valid),
        .in_ready  (cap_ready),
        .in_data   (link.data_io),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data),
        .level     (level)
    );

    // pins
    assign link.k                    = s.k;
    assign link.k_n                  = s.k_n;
    assign link.c                    = s.c;
    assign link.c_n                  = s.c_n;
    assign link.load_n               = s.load_n;
    assign link.read_not_write       = s.rnw;
    assign link.address_inputs       = s.addr[ADDR_W-1:1];
    assign link.burst_start_addr_bit = s.addr[0];
    assign link.byte_write_n         = s.bw_n;
    assign link.dll_off_n            = s.dll_off_n;
    assign link.ctl_data_o           = s.dq_o;
    assign link.ctl_data_oe_n        = s.dq_oe_n;
    assign cmd_ready                 = s.cmd_ready;

endmodule : ddrs_sram_ctl

// file: hdl/ddrs_sram_dev.sv
// Purpose: device end of a common-I/O double-data-rate SRAM with fixed two-word bursts
// Assumes: link pins come from controller flops on the same clk, so no synchroniser
// Notes:   input clock edges are found by comparing each pin with its last value
//
// What this block does
// - inputs other than dll_off_n sampled only on input clock rising edges; dll_off_n is sampled every clk
// - addresses captured on true input clock only
// - one address bus for reads and writes
// - read_not_write high means read
// - load_n low starts a new cycle
// - read address registered at command edge
// - array holds 1M words of 18 bits
// - every command moves exactly two words
// - read returns two 18-bit words on data_io
// - word one at output bar edge, two next
// - back-to-back reads stream without gaps
// - output clocks tied high: use input clocks
// - burst finishes, then drivers float
// - echo clocks follow output clock, aligned with data
// - echo clocks run free always
// - byte_write_n low enables a lane
// - dll_off_n low switches the loop off
// - controller gives each device its own load_n
// - write words on next true, then bar edge
// - lane 0 bits 0-8, lane 1 bits 9-17
// - second burst word flips the start bit
module ddrs_sram_dev #(
    parameter int ADDR_W = ddrs_pkg::ADDR_W,
    parameter int DATA_W = ddrs_pkg::DATA_W,
    parameter int LANE_W = ddrs_pkg::LANE_W,
    parameter int LANES  = ddrs_pkg::LANES,
    parameter int WORDS  = ddrs_pkg::WORDS
) (
    input  wire logic   clk,
    input  wire logic   nrst,
    ddrs_link_if.device link,
    output logic        dll_active,
    output logic        single_clk_seen,
    output logic        read_busy
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              k_prev;
        logic              kn_prev;
        logic              oc_prev;
        logic              ocn_prev;
        logic              mode_known;
        logic              single_clk;
        logic              rd_cap_v;
        logic [ADDR_W-1:0] rd_cap;
        logic              rd_out_v;
        logic [ADDR_W-1:0] rd_out;
        logic              rd_w2;
        logic              wr_cap_v;
        logic [ADDR_W-1:0] wr_cap;
        logic              wr_act_v;
        logic [ADDR_W-1:0] wr_act;
        logic [DATA_W-1:0] dq_o;
        logic              dq_oe_n;
        logic              echo;
        logic              echo_n;
        logic              dll_on;
        logic              rd_busy;
    } ddrs_dev_st_t;

    ddrs_dev_st_t      s;
    ddrs_dev_st_t      next_s;
    logic [DATA_W-1:0] mem [0:WORDS-1];
    logic              k_rise;
    logic              kn_rise;
    logic              oc;
    logic              ocn;
    logic              oc_rise;
    logic              ocn_rise;
    logic              we;
    logic [ADDR_W-1:0] waddr;
    logic [LANES-1:0]  wbw_n;
    logic [DATA_W-1:0] wmask;
    logic [ADDR_W-1:0] raddr;
    logic [ADDR_W-1:0] cmd_addr;

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    // rising edges only; falling edges are never looked at
    assign k_rise   = link.k & ~s.k_prev;
    assign kn_rise  = link.k_n & ~s.kn_prev;
    // output timing pair, swapped for the input pair in single clock mode
    assign oc       = s.single_clk ? link.k : link.c;
    assign ocn      = s.single_clk ? link.k_n : link.c_n;
    assign oc_rise  = oc & ~s.oc_prev;
    assign ocn_rise = ocn & ~s.ocn_prev;
    // one address bus for both command kinds
    assign cmd_addr = {link.address_inputs, link.burst_start_addr_bit};

    // lane enables spread over the data bits
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        assign wmask[g*LANE_W +: LANE_W] = {LANE_W{~wbw_n[g]}};
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // command capture, write stages, read output stages
    always_comb begin
        next_s          = s;
        next_s.k_prev   = link.k;
        next_s.kn_prev  = link.k_n;
        next_s.oc_prev  = oc;
        next_s.ocn_prev = ocn;
        next_s.dll_on   = link.dll_off_n;
        next_s.echo     = oc;
        next_s.echo_n   = ~oc;
        we              = 1'b0;
        waddr           = s.wr_cap;
        wbw_n           = link.byte_write_n;
        raddr           = s.rd_out;

        // strap: c_n still high at the first k edge means tied high
        if (k_rise && !s.mode_known) begin
            next_s.mode_known = 1'b1;
            next_s.single_clk = link.c_n;
        end

        // true input clock edge: new command and first write word
        if (k_rise) begin
            if (s.wr_cap_v) begin
                we    = 1'b1;
                waddr = s.wr_cap;
            end
            next_s.wr_act_v = s.wr_cap_v;
            next_s.wr_act   = s.wr_cap;
            next_s.rd_out_v = s.rd_cap_v;
            next_s.rd_out   = s.rd_cap;
            // load_n high starts nothing
            next_s.rd_cap_v = !link.load_n && link.read_not_write;
            next_s.wr_cap_v = !link.load_n && !link.read_not_write;
            if (!link.load_n) begin
                next_s.rd_cap = cmd_addr;
                next_s.wr_cap = cmd_addr;
            end
        end

        // complementary input edge: second write word, start bit flipped
        if (kn_rise && s.wr_act_v) begin
            we              = 1'b1;
            waddr           = {s.wr_act[ADDR_W-1:1], ~s.wr_act[0]};
            next_s.wr_act_v = 1'b0;
        end

        // output bar edge: first read word or release the bus
        if (ocn_rise) begin
            if (s.rd_out_v) begin
                raddr           = s.rd_out;
                next_s.dq_o     = mem[raddr];
                next_s.dq_oe_n  = 1'b0;
                next_s.rd_w2    = 1'b1;
                next_s.rd_out_v = 1'b0;
            end else begin
                next_s.dq_oe_n  = 1'b1;
            end
        end

        // output true edge: second read word or release the bus
        if (oc_rise) begin
            if (s.rd_w2) begin
                raddr          = {s.rd_out[ADDR_W-1:1], ~s.rd_out[0]};
                next_s.dq_o    = mem[raddr];
                next_s.dq_oe_n = 1'b0;
                next_s.rd_w2   = 1'b0;
            end else begin
                next_s.dq_oe_n = 1'b1;
            end
        end
        // busy flag registered alongside the drivers
        next_s.rd_busy = ~next_s.dq_oe_n;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // state register, drivers off after reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s         <= '0;
            s.kn_prev <= 1'b1;  // idle levels: no false edge after reset
            s.oc_prev <= 1'b1;
            s.ocn_prev <= 1'b1;
            s.dq_oe_n <= 1'b1;
            s.echo_n  <= 1'b1;
            s.dll_on  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // array write with per-lane merge
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= (mem[waddr] & ~wmask) | (link.data_io & wmask);
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign link.dev_data_o    = s.dq_o;
    assign link.dev_data_oe_n = s.dq_oe_n;
    assign link.echo_clock    = s.echo;
    assign link.echo_clock_n  = s.echo_n;
    assign dll_active         = s.dll_on;
    assign single_clk_seen    = s.single_clk;
    assign read_busy          = s.rd_busy;        // data drivers on

endmodule : ddrs_sram_dev

// file: include/ddrs_link_if.sv
// Purpose: pins between the memory controller and the SRAM device
// Assumes: both ends clocked by the same clk
// Notes:   the shared data pins are resolved here from the two output enables
interface ddrs_link_if #(
    parameter int ADDR_W = ddrs_pkg::ADDR_W,
    parameter int DATA_W = ddrs_pkg::DATA_W,
    parameter int LANES  = ddrs_pkg::LANES
);
    logic              k;
    logic              k_n;
    logic              c;
    logic              c_n;
    logic              load_n;
    logic              read_not_write;
    logic [ADDR_W-2:0] address_inputs;
    logic              burst_start_addr_bit;
    logic [LANES-1:0]  byte_write_n;
    logic              dll_off_n;
    logic [DATA_W-1:0] ctl_data_o;
    logic              ctl_data_oe_n;
    logic [DATA_W-1:0] dev_data_o;
    logic              dev_data_oe_n;
    logic [DATA_W-1:0] data_io;
    logic              echo_clock;
    logic              echo_clock_n;

    // level on the shared data pins; the device wins a clash
    assign data_io = !dev_data_oe_n ? dev_data_o :
                     (!ctl_data_oe_n ? ctl_data_o : '0);

    modport device (
        input  k,
        input  k_n,
        input  c,
        input  c_n,
        input  load_n,
        input  read_not_write,
        input  address_inputs,
        input  burst_start_addr_bit,
        input  byte_write_n,
        input  dll_off_n,
        input  data_io,
        output dev_data_o,
        output dev_data_oe_n,
        output echo_clock,
        output echo_clock_n
    );

    modport controller (
        output k,
        output k_n,
        output c,
        output c_n,
        output load_n,
        output read_not_write,
        output address_inputs,
        output burst_start_addr_bit,
        output byte_write_n,
        output dll_off_n,
        output ctl_data_o,
        output ctl_data_oe_n,
        input  data_io,
        input  echo_clock,
        input  echo_clock_n
    );
endinterface : ddrs_link_if

// file: include/ddrs_pkg.sv
// Purpose: shared constants for the two-word burst common-I/O SRAM port
// Assumes: both ends run on one 50 MHz clock; the controller divides it for the link clocks
// Notes:   cycle counts are taken from the cycle in which a command shows on the pins
package ddrs_pkg;

    // ------------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W     = 20;       // word address incl. burst start bit
    localparam int DATA_W     = 18;       // word width
    localparam int LANE_W     = 9;        // bits gated by one byte write enable
    localparam int LANES      = 2;        // byte lanes per word
    localparam int WORDS      = 1048576;  // words in the array
    localparam int BURST_LEN  = 2;        // words per command, fixed

    // ------------------------------------------------------------------
    // timing, in clk cycles after the command cycle
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;    // 50 MHz
    localparam int RD_WORD1_CYC  = 4;     // first read word on the bus
    localparam int RD_WORD2_CYC  = 5;     // second read word on the bus
    localparam int WR_WORD1_CYC  = 2;     // first write word on the bus
    localparam int WR_WORD2_CYC  = 3;     // second write word on the bus
    localparam int RD_SH_W       = RD_WORD2_CYC + 1;
    localparam int WR_SH_W       = WR_WORD2_CYC;

    // ------------------------------------------------------------------
    // return buffer
    // ------------------------------------------------------------------
    localparam int FIFO_DEPTH = 16;       // read words buffered
    localparam int FIFO_SLACK = 8;        // free words kept for reads in flight

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic [1:0] BW_NONE = 2'h3;  // no lane written

endpackage : ddrs_pkg
